// [logic/twsp_defs.svh]
// Constants of the two-wire sensor serial port: offsets, fields, timing
`ifndef TWSP_DEFS_SVH
`define TWSP_DEFS_SVH

// Reference clock rate
`define TWSP_REF_CLK_KHZ   10000

// Port reset when a transaction outlives this time
`define TWSP_TIMEOUT_MS    90
`define TWSP_TIMEOUT_CYC   (`TWSP_TIMEOUT_MS * `TWSP_REF_CLK_KHZ)

// Data preparation time after a read address
`define TWSP_PREP_US       100
`define TWSP_PREP_CYC      (`TWSP_PREP_US * `TWSP_REF_CLK_KHZ / 1000)

// Spacing between commands, kept after every command
`define TWSP_GAP_US        100
`define TWSP_GAP_CYC       (`TWSP_GAP_US * `TWSP_REF_CLK_KHZ / 1000)

// Serial clock made by the host
`define TWSP_SCK_PERIOD_NS 800
`define TWSP_SCK_HALF_CYC  (`TWSP_SCK_PERIOD_NS * `TWSP_REF_CLK_KHZ / 2000000)

// Device register addresses and fields
`define TWSP_ADDR_CFG      7'h00
`define TWSP_ADDR_STATUS   7'h01
`define TWSP_CFG_RESET_BIT 7
`define TWSP_CFG_PD_BIT    6
`define TWSP_CFG_RESET     8'h00
`define TWSP_DIR_WRITE     1'b1

// Bit counts of one transaction
`define TWSP_BYTE_LAST     5'h07
`define TWSP_BITS_ADDR     5'h08
`define TWSP_BITS_LAST     5'h0F

// Host controller registers on its plain port
`define TWSP_HREG_CMD      4'h0
`define TWSP_HREG_STAT     4'h1

`endif

// [logic/twsp_pkg.sv]
// Types shared by both ends of the two-wire sensor serial port
`default_nettype none
package twsp_pkg;

   // Device end states, one-hot
   typedef enum logic [2:0] {
      TWSP_D_ADDR  = 3'b001,
      TWSP_D_WDATA = 3'b010,
      TWSP_D_RDATA = 3'b100
   } twsp_dev_state_t;

   // Host end states, one-hot
   typedef enum logic [3:0] {
      TWSP_H_IDLE = 4'b0001,
      TWSP_H_LOW  = 4'b0010,
      TWSP_H_HIGH = 4'b0100,
      TWSP_H_GAP  = 4'b1000
   } twsp_host_state_t;

   // Whole state of the device end
   typedef struct packed {
      twsp_dev_state_t st;
      logic [4:0]      bits;
      logic [7:0]      shin;
      logic [7:0]      shout;
      logic [7:0]      cfg;
      logic            drive;
      logic [23:0]     tmr;
      logic            sck1;
      logic            sck2;
      logic            sck3;
      logic            sdi1;
      logic            sdi2;
   } twsp_dev_regs_t;

   // Whole state of the host end
   typedef struct packed {
      twsp_host_state_t st;
      logic [11:0]      div;
      logic [4:0]       bits;
      logic [15:0]      sh;
      logic             wr;
      logic             sck;
      logic             sdo;
      logic             oe;
      logic [7:0]       rdsr;
      logic [7:0]       rsp;
      logic             busy;
      logic [15:0]      rdata;
      logic             sdi1;
      logic             sdi2;
   } twsp_host_regs_t;

endpackage : twsp_pkg
`default_nettype wire

// [logic/twsp_link_if.sv]
// Two-wire link between host and device: clock and shared data line
`default_nettype none
interface twsp_link_if;
   logic sck;
   logic host_sdio_o;
   logic host_sdio_oe;
   logic dev_sdio_o;
   logic dev_sdio_oe;
   logic sdio;

   // Resolved line; an undriven line reads high as if pulled up
   assign sdio = host_sdio_oe ? host_sdio_o :
                 (dev_sdio_oe ? dev_sdio_o : 1'b1);

   modport dev (
      input  sck,
      input  sdio,
      output dev_sdio_o,
      output dev_sdio_oe
   );

   modport host (
      output sck,
      output host_sdio_o,
      output host_sdio_oe,
      input  sdio
   );
endinterface : twsp_link_if
`default_nettype wire

// [logic/twsp_dev_end.sv]
// Device end of the two-wire sensor serial port
//
// Contract
// - Only host starts transfers; device only answers.
// - Host alone makes the serial clock.
// - Write is address byte with MSB 1, data.
// - Host changes data on fall; sampled on rise.
// - Read is address byte MSB 0, device data.
// - Host releases data before fall after address.
// - Host waits 100 us after read address.
// - Device drives after address, releases after data.
// - Device holds final data bit until fall.
// - Device drives line only returning read data.
// - Power-down write leaves device pin released.
// - Write to unassigned address leaves pin released.
// - Host spaces two writes by 100 us.
// - Host spaces write then read by 100 us.
// - Next command falls 250 ns after read.
// - Port resets if transaction exceeds 90 ms.
// - Unassigned write ignored; unassigned read gives zero.
// - Host should not leave data line floating; the host end leaves it undriven from reset until its first command and after each read.
// - Host may poll status for product identity.
// - Host may verify writes by reading back.
// - Power-down is configuration bit 6.
// - No timeout in power-down; no partial commands.
//
// The plain strobed port was chosen for this implementation.
`include "twsp_defs.svh"
`default_nettype none
module twsp_dev_end #(
   parameter logic [23:0] TIMEOUT_CYC = 24'(`TWSP_TIMEOUT_CYC),
   // Identity value is arbitrary
   parameter logic [2:0]  PRODUCT_ID  = 3'h5
) (
   input  wire logic  ref_clk,
   input  wire logic  rst_n,
   twsp_link_if.dev   link,
   input  wire logic  awake,
   output logic       power_down,
   output logic [7:0] cfg_value,
   output logic       port_timeout
);

   twsp_pkg::twsp_dev_regs_t r_r;
   twsp_pkg::twsp_dev_regs_t r_nxt;

   logic       rise;
   logic       fall;
   logic       pd;
   logic       active;
   logic [6:0] rx_addr;
   logic [7:0] rx_byte;
   logic [7:0] rd_val;
   logic       tmo;

   // Edges of the synchronised clock; sck1 and sdi1 feed nothing else
   assign rise    = r_r.sck2 & ~r_r.sck3;
   assign fall    = ~r_r.sck2 & r_r.sck3;
   assign pd      = r_r.cfg[`TWSP_CFG_PD_BIT];
   assign rx_byte = {r_r.shin[6:0], r_r.sdi2};
   assign rx_addr = rx_byte[6:0];

   // A transaction is open from its first bit until the sixteenth rise
   assign active = ((r_r.st != twsp_pkg::TWSP_D_ADDR) ||
                    (r_r.bits != 5'h00)) &&
                   !((r_r.st == twsp_pkg::TWSP_D_RDATA) &&
                     (r_r.bits == `TWSP_BITS_ADDR));

   // Timer is held at zero in power-down, so a partial command hangs there
   assign tmo = !pd && (r_r.tmr >= TIMEOUT_CYC);

   // Read data selection; unassigned addresses read all zeros
   always_comb begin
      case (rx_addr)
         `TWSP_ADDR_CFG: begin
            rd_val = r_r.cfg;
         end
         `TWSP_ADDR_STATUS: begin
            rd_val = {PRODUCT_ID, 4'h0, awake};
         end
         default: begin
            rd_val = 8'h00;
         end
      endcase
   end

   // Next state of the whole port
   always_comb begin
      r_nxt      = r_r;
      r_nxt.sck1 = link.sck;
      r_nxt.sck2 = r_r.sck1;
      r_nxt.sck3 = r_r.sck2;
      r_nxt.sdi1 = link.sdio;
      r_nxt.sdi2 = r_r.sdi1;

      // Transaction timer runs only inside a transaction
      if (active && !pd) begin
         r_nxt.tmr = r_r.tmr + 24'h00_0001;
      end else begin
         r_nxt.tmr = 24'h00_0000;
      end

      case (r_r.st)
         // Address byte, sampled on rises only, MSB first
         twsp_pkg::TWSP_D_ADDR: begin
            if (rise) begin
               r_nxt.shin = rx_byte;
               r_nxt.bits = r_r.bits + 5'h01;
               if (r_r.bits == `TWSP_BYTE_LAST) begin
                  r_nxt.bits = 5'h00;
                  if (r_r.shin[6] == `TWSP_DIR_WRITE) begin
                     r_nxt.st = twsp_pkg::TWSP_D_WDATA;
                     // Idle out-shifter keeps the address: shout is reused
                     r_nxt.shout = rx_byte;
                  end else begin
                     // Drive the first data bit right after the rise
                     r_nxt.st    = twsp_pkg::TWSP_D_RDATA;
                     r_nxt.shout = rd_val;
                     r_nxt.drive = 1'b1;
                  end
               end
            end
         end

         // Data byte of a write; committed on its eighth rise
         twsp_pkg::TWSP_D_WDATA: begin
            if (rise) begin
               r_nxt.shin = rx_byte;
               r_nxt.bits = r_r.bits + 5'h01;
               if (r_r.bits == `TWSP_BYTE_LAST) begin
                  r_nxt.bits = 5'h00;
                  r_nxt.st   = twsp_pkg::TWSP_D_ADDR;
                  // Writes never touch the pin: it stays released
                  if (r_r.shout[6:0] == `TWSP_ADDR_CFG) begin
                     if (pd) begin
                        // Only the power-down bit is writable asleep
                        r_nxt.cfg[`TWSP_CFG_PD_BIT] =
                           rx_byte[`TWSP_CFG_PD_BIT];
                     end else begin
                        r_nxt.cfg = rx_byte;
                     end
                     // Reset bit clears itself at once
                     r_nxt.cfg[`TWSP_CFG_RESET_BIT] = 1'b0;
                  end
                  // Any other address changes nothing here
               end
            end
         end

         // Data byte of a read, shifted out on falls
         twsp_pkg::TWSP_D_RDATA: begin
            if (rise && (r_r.bits != `TWSP_BITS_ADDR)) begin
               r_nxt.bits = r_r.bits + 5'h01;
            end
            if (fall) begin
               if (r_r.bits == `TWSP_BITS_ADDR) begin
                  // This fall opens the next command
                  r_nxt.drive = 1'b0;
                  r_nxt.bits  = 5'h00;
                  r_nxt.st    = twsp_pkg::TWSP_D_ADDR;
               end else if (r_r.bits != 5'h00) begin
                  // Fall before the first data rise keeps bit 7
                  r_nxt.shout = {r_r.shout[6:0], 1'b0};
               end
            end
         end

         default: begin
            r_nxt.st    = twsp_pkg::TWSP_D_ADDR;
            r_nxt.bits  = 5'h00;
            r_nxt.drive = 1'b0;
         end
      endcase

      // Timeout drops the transaction and frees the line
      if (tmo) begin
         r_nxt.st    = twsp_pkg::TWSP_D_ADDR;
         r_nxt.bits  = 5'h00;
         r_nxt.drive = 1'b0;
         r_nxt.tmr   = 24'h00_0000;
      end
   end

   // State register
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         r_r <= '{st: twsp_pkg::TWSP_D_ADDR, cfg: `TWSP_CFG_RESET,
                  sck1: 1'b1, sck2: 1'b1, sck3: 1'b1, default: '0};
      end else begin
         r_r <= r_nxt;
      end
   end

   // Pin is an input except while returning read data, and never asleep
   assign link.dev_sdio_o  = r_r.shout[7];
   assign link.dev_sdio_oe = r_r.drive & ~pd;

   // Core-facing view of the configuration
   assign power_down   = pd;
   assign cfg_value    = r_r.cfg;
   assign port_timeout = tmo;

endmodule : twsp_dev_end
`default_nettype wire

// [logic/twsp_host_end.sv]
// Host end of the two-wire sensor serial port
`include "twsp_defs.svh"
`default_nettype none
module twsp_host_end #(
   parameter int HALF_CYC = `TWSP_SCK_HALF_CYC,
   parameter int PREP_CYC = `TWSP_PREP_CYC,
   parameter int GAP_CYC  = `TWSP_GAP_CYC
) (
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   twsp_link_if.host        link,
   input  wire logic [3:0]  bus_addr,
   input  wire logic [15:0] bus_wdata,
   input  wire logic        bus_wr,
   input  wire logic        bus_rd,
   output logic [15:0]      bus_rdata
);

   twsp_pkg::twsp_host_regs_t r_r;
   twsp_pkg::twsp_host_regs_t r_nxt;

   logic [11:0] lim;
   logic        go;

   // Low phase length: longer for the first bit, and the read delay
   always_comb begin
      if (r_r.bits == 5'h00) begin
         lim = 12'(2 * HALF_CYC - 1);
      end else if (!r_r.wr && (r_r.bits == `TWSP_BITS_ADDR)) begin
         lim = 12'(PREP_CYC - 1);
      end else begin
         lim = 12'(HALF_CYC - 1);
      end
   end

   // A command is taken only when the port is idle
   assign go = bus_wr && (bus_addr == `TWSP_HREG_CMD) &&
               (r_r.st == twsp_pkg::TWSP_H_IDLE);

   always_comb begin
      r_nxt      = r_r;
      r_nxt.sdi1 = link.sdio;
      r_nxt.sdi2 = r_r.sdi1;

      // Read data stand for one cycle only
      r_nxt.rdata = 16'h0000;
      if (bus_rd && (bus_addr == `TWSP_HREG_STAT)) begin
         r_nxt.rdata = {r_r.busy, 7'h00, r_r.rsp};
      end

      case (r_r.st)
         twsp_pkg::TWSP_H_IDLE: begin
            r_nxt.sck = 1'b1;
            if (go) begin
               r_nxt.sh   = bus_wdata;
               r_nxt.wr   = bus_wdata[15];
               r_nxt.bits = 5'h00;
               r_nxt.div  = 12'h000;
               r_nxt.busy = 1'b1;
               r_nxt.sck  = 1'b0;
               r_nxt.st   = twsp_pkg::TWSP_H_LOW;
            end
         end

         // Data set in the low phase, late for the first bit so a
         // device still holding its last read bit has let go
         twsp_pkg::TWSP_H_LOW: begin
            if ((r_r.wr || (r_r.bits < `TWSP_BITS_ADDR)) &&
                ((r_r.bits != 5'h00) || (r_r.div >= 12'(HALF_CYC)))) begin
               r_nxt.oe  = 1'b1;
               r_nxt.sdo = r_r.sh[15];
            end
            if (r_r.div == lim) begin
               r_nxt.div = 12'h000;
               r_nxt.sck = 1'b1;
               r_nxt.st  = twsp_pkg::TWSP_H_HIGH;
            end else begin
               r_nxt.div = r_r.div + 12'h001;
            end
         end

         // High phase; device data sampled at its end
         twsp_pkg::TWSP_H_HIGH: begin
            if (!r_r.wr && (r_r.bits == `TWSP_BYTE_LAST)) begin
               r_nxt.oe = 1'b0;
            end
            if (r_r.div == 12'(HALF_CYC - 1)) begin
               r_nxt.div  = 12'h000;
               r_nxt.sh   = {r_r.sh[14:0], 1'b0};
               r_nxt.bits = r_r.bits + 5'h01;
               if (!r_r.wr && (r_r.bits >= `TWSP_BITS_ADDR)) begin
                  r_nxt.rdsr = {r_r.rdsr[6:0], r_r.sdi2};
               end
               if (r_r.bits == `TWSP_BITS_LAST) begin
                  // Clock stays high; on a read the device holds its last bit
                  r_nxt.st = twsp_pkg::TWSP_H_GAP;
                  if (!r_r.wr) begin
                     r_nxt.rsp = {r_r.rdsr[6:0], r_r.sdi2};
                  end
               end else begin
                  r_nxt.sck = 1'b0;
                  r_nxt.st  = twsp_pkg::TWSP_H_LOW;
               end
            end else begin
               r_nxt.div = r_r.div + 12'h001;
            end
         end

         // Spacing after every command covers all minimum gaps
         twsp_pkg::TWSP_H_GAP: begin
            // Last bit kept: clock is still high, so data may not move
            if (r_r.wr) begin
               r_nxt.oe = 1'b1;
            end
            if (r_r.div == 12'(GAP_CYC - 1)) begin
               r_nxt.div  = 12'h000;
               r_nxt.busy = 1'b0;
               r_nxt.st   = twsp_pkg::TWSP_H_IDLE;
            end else begin
               r_nxt.div = r_r.div + 12'h001;
            end
         end

         default: begin
            r_nxt.st  = twsp_pkg::TWSP_H_IDLE;
            r_nxt.oe  = 1'b0;
            r_nxt.sck = 1'b1;
         end
      endcase
   end

   // State register; clock idles high, line undriven after reset
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         r_r <= '{st: twsp_pkg::TWSP_H_IDLE, sck: 1'b1, sdo: 1'b1,
                  sdi1: 1'b1, sdi2: 1'b1, default: '0};
      end else begin
         r_r <= r_nxt;
      end
   end

   assign link.sck          = r_r.sck;
   assign link.host_sdio_o  = r_r.sdo;
   assign link.host_sdio_oe = r_r.oe;
   assign bus_rdata         = r_r.rdata;

endmodule : twsp_host_end
`default_nettype wire

// [verif/twsp_link_chk.sv]
// Link checker for the two-wire sensor serial port
`default_nettype none
module twsp_link_chk (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic sck,
   input wire logic host_sdio_o,
   input wire logic host_sdio_oe,
   input wire logic dev_sdio_o,
   input wire logic dev_sdio_oe,
   input wire logic power_down
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [4:0] cnt_r;
   logic       dir_r;
   logic       sck_r;

   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   // Rises seen in the frame; direction taken from the first one
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= 5'h00;
         dir_r <= 1'b1;
         sck_r <= 1'b1;
      end else begin
         sck_r <= sck;
         if (sck && !sck_r) begin
            cnt_r <= (cnt_r == 5'h10) ? 5'h01 : cnt_r + 5'h01;
            if (cnt_r == 5'h00 || cnt_r == 5'h10) begin
               dir_r <= host_sdio_o;
            end
         end
      end
   end

   sequence addr_done_rd;
      $rose(sck) && cnt_r == 5'h07 && !dir_r;
   endsequence
   sequence turn_fall;
      $fell(sck) && cnt_r == 5'h08 && !dir_r;
   endsequence
   sequence last_fall;
      $fell(sck) && cnt_r == 5'h10;
   endsequence
   sequence last_rise;
      $rose(sck) && cnt_r == 5'h0F;
   endsequence

   // Line ownership
   a_no_fight: assert property (!(host_sdio_oe && dev_sdio_oe))
      else $error("both ends drive the line");
   a_oe_read_only: assert property (dev_sdio_oe |->
      !dir_r && cnt_r >= 5'h08)
      else $error("device drives outside read data");
   a_pd_quiet: assert property (power_down |-> !dev_sdio_oe)
      else $error("device drives in power-down");
   // Turnaround
   a_drive_start: assert property (addr_done_rd ##0 !power_down |->
      ##[1:6] dev_sdio_oe)
      else $error("device late to drive read data");
   a_release_bound: assert property (last_fall |-> ##[1:5] !dev_sdio_oe)
      else $error("device late to release line");
   a_hold_final: assert property (cnt_r == 5'h10 && sck && dev_sdio_oe
      |=> dev_sdio_oe && $stable(dev_sdio_o))
      else $error("final bit not held");
   a_host_turn: assert property (turn_fall |-> !host_sdio_oe)
      else $error("host still drives at turnaround");
   a_prep_wait: assert property (turn_fall |-> !sck [*8])
      else $error("clock resumed too soon");
   // Clock rests high after the last rise before any new command
   a_gap_hold: assert property (last_rise |-> sck [*8])
      else $error("next command started too soon");
   // Data stays put while the clock is high
   a_host_hold: assert property (sck && $past(sck) && host_sdio_oe
      && $past(host_sdio_oe) |-> $stable(host_sdio_o))
      else $error("host data moved while clock high");
   a_dev_hold: assert property (sck && $past(sck) && dev_sdio_oe
      && $past(dev_sdio_oe) |-> $stable(dev_sdio_o))
      else $error("device data moved while clock high");
endmodule : twsp_link_chk
`default_nettype wire

// [verif/test_two_wire_sensor_serial_port.sv]
// Bench joining host and device ends over the link
`include "twsp_defs.svh"
`default_nettype none
module test_two_wire_sensor_serial_port;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [2:0] PID = 3'h5; // Arbitrary identity value
   localparam int         TO  = 2000;
   logic        ref_clk, rst_n, awake, pd, tmo2;
   logic        bus_wr, bus_rd;
   logic [3:0]  bus_addr;
   logic [15:0] bus_wdata, bus_rdata, frame, s;
   logic [7:0]  cfg, cfg2;
   int          mismatches, checked, pulses;

   twsp_link_if link ();
   twsp_link_if link2 ();
   twsp_host_end #(.HALF_CYC(4), .PREP_CYC(40), .GAP_CYC(40))
      twsp_host_end_inst (.ref_clk(ref_clk), .rst_n(rst_n), .link(link),
      .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
      .bus_rd(bus_rd), .bus_rdata(bus_rdata));
   twsp_dev_end #(.TIMEOUT_CYC(24'h00_07d0), .PRODUCT_ID(PID))
      twsp_dev_end_inst (.ref_clk(ref_clk), .rst_n(rst_n), .link(link),
      .awake(awake), .power_down(pd), .cfg_value(cfg), .port_timeout());
   // Second device fed by a hand-made host that can break off a frame
   twsp_dev_end #(.TIMEOUT_CYC(24'h00_07d0), .PRODUCT_ID(PID))
      twsp_dev_end_inst2 (.ref_clk(ref_clk), .rst_n(rst_n), .link(link2),
      .awake(awake), .power_down(), .cfg_value(cfg2), .port_timeout(tmo2));
   twsp_link_chk twsp_link_chk_inst (.ref_clk(ref_clk), .rst_n(rst_n),
      .sck(link.sck), .host_sdio_o(link.host_sdio_o),
      .host_sdio_oe(link.host_sdio_oe), .dev_sdio_o(link.dev_sdio_o),
      .dev_sdio_oe(link.dev_sdio_oe), .power_down(pd));

   // Frame as seen on the wire, first bit ends up on top
   always @(posedge link.sck) frame <= {frame[14:0], link.sdio};

   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end

   task automatic chk(input string what, input logic [15:0] exp, got);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic bwr(input logic [3:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      bus_addr <= a;
      bus_wdata <= d;
      bus_wr <= 1'b1;
      @(posedge ref_clk);
      bus_wr <= 1'b0;
   endtask : bwr

   // Read data stands only in the cycle after the strobe
   task automatic brd(input logic [3:0] a, output logic [15:0] d);
      @(posedge ref_clk);
      bus_addr <= a;
      bus_rd <= 1'b1;
      @(posedge ref_clk);
      bus_rd <= 1'b0;
      #1 d = bus_rdata;
   endtask : brd

   // One link command, polled to completion under a bound
   task automatic cmd(input logic wr, input logic [6:0] a,
                      input logic [7:0] d, input logic [7:0] exp);
      int n;
      bwr(`TWSP_HREG_CMD, {wr, a, d});
      n = 0;
      do begin
         brd(`TWSP_HREG_STAT, s);
         n++;
      end while (s[15] !== 1'b0 && n < 2000);
      if (n >= 2000) begin
         mismatches++;
         stop_test();
      end
      chk("frame", {wr, a, wr ? d : exp}, frame);
      if (!wr) chk("read byte", {8'h00, exp}, s);
   endtask : cmd

   // Hand-made host: data moves while the clock is low
   task automatic bang(input logic [15:0] v, input int n);
      for (int i = 0; i < n; i++) begin
         repeat (4) @(posedge ref_clk);
         link2.sck <= 1'b0;
         repeat (2) @(posedge ref_clk);
         link2.host_sdio_o <= v[15-i];
         repeat (2) @(posedge ref_clk);
         link2.sck <= 1'b1;
      end
   endtask : bang

   initial begin
      rst_n = 1'b0;
      awake = 1'b1;
      bus_wr = 1'b0;
      bus_rd = 1'b0;
      bus_addr = 4'h0;
      bus_wdata = 16'h0000;
      link2.sck = 1'b1;
      link2.host_sdio_o = 1'b1;
      link2.host_sdio_oe = 1'b1;
      mismatches = 0;
      checked = 0;
      repeat (10) @(posedge ref_clk);
      rst_n <= 1'b1;
      #1 chk("cfg", 16'h0000, 16'(cfg));
      chk("idle sck", 16'h0001, 16'(link.sck));
      // Write, read back, identity with both awake levels
      cmd(1'b1, 7'h00, 8'h01, 8'h00);
      chk("cfg", 16'h0001, 16'(cfg));
      chk("host oe", 16'h0001, 16'(link.host_sdio_oe));
      cmd(1'b0, 7'h00, 8'h00, 8'h01);
      cmd(1'b0, 7'h01, 8'h00, {PID, 4'h0, 1'b1});
      awake <= 1'b0;
      cmd(1'b0, 7'h01, 8'h00, {PID, 4'h0, 1'b0});
      $display("basic access done");
      // Unassigned places change nothing and read zero
      cmd(1'b1, 7'h77, 8'h54, 8'h00);
      chk("cfg", 16'h0001, 16'(cfg));
      chk("dev oe", 16'h0000, 16'(link.dev_sdio_oe));
      cmd(1'b0, 7'h05, 8'h00, 8'h00);
      brd(4'h5, s);
      chk("host unmapped", 16'h0000, s);
      $display("unassigned done");
      // Power-down: line left to the pull-up, then normal again
      cmd(1'b1, 7'h00, 8'h41, 8'h00);
      chk("pd", 16'h0001, 16'(pd));
      cmd(1'b0, 7'h00, 8'h00, 8'hff);
      cmd(1'b1, 7'h00, 8'h01, 8'h00);
      chk("pd", 16'h0000, 16'(pd));
      chk("cfg", 16'h0001, 16'(cfg));
      chk("dev oe", 16'h0000, 16'(link.dev_sdio_oe));
      $display("power-down done");
      // Broken-off frame must be dropped by the timer
      bang(16'ha000, 3);
      pulses = 0;
      repeat (TO + 300) begin
         @(posedge ref_clk);
         #1 if (tmo2 === 1'b1) pulses++;
      end
      chk("timeout pulses", 16'h0001, 16'(pulses));
      bang({1'b1, 7'h00, 8'h03}, 16);
      repeat (10) @(posedge ref_clk);
      chk("cfg after resync", 16'h0003, 16'(cfg2));
      $display("timeout done");
      stop_test();
   end

   task automatic stop_test();
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : stop_test
endmodule : test_two_wire_sensor_serial_port
`default_nettype wire
